//--- regbuf_pkg.sv
package regbuf_pkg;

  // Main data path: data bits 0 to 21, the ones that parity covers.
  localparam int unsigned MAIN_W = 22;
  // Each control group (select, termination, clock enable) has two lines.
  localparam int unsigned PAIR_W = 2;
  // Depth of the skid buffer between the input stage and the output registers.
  localparam int unsigned BUF_DEPTH = 2;
  // Clock cycles for which a parity error stays latched low.
  localparam logic [1:0] ERR_HOLD_CYC = 2'h2;
  // Reset values of the main data output register and of the two-line output registers.
  localparam logic [MAIN_W-1:0] MAIN_RST = 22'h000000;
  localparam logic [PAIR_W-1:0] PAIR_RST = 2'h0;

  // One captured input word; 22 + 2 + 2 + 2 = 28 lines of register path.
  typedef struct packed {
    logic [MAIN_W-1:0] main;     // Main data lines.
    logic [PAIR_W-1:0] sel_n;    // Active-low chip selects.
    logic [PAIR_W-1:0] odt;      // Termination lines.
    logic [PAIR_W-1:0] cke;      // Clock-enable lines.
  } word_t;

  // One buffer entry: the word and whether its main data is gated off.
  typedef struct packed {
    logic  gate;                 // High when the main data must not load.
    word_t w;                    // Captured word.
  } entry_t;

  // All state of the buffer module.
  typedef struct packed {
    entry_t [BUF_DEPTH-1:0] mem; // Skid buffer storage.
    logic                   wr;  // Write index.
    logic                   rd;  // Read index.
    logic [1:0]             cnt; // Entries held.
    word_t                  q;   // Output registers.
    logic                   out_valid; // New word loaded this cycle.
    logic                   par_pend;  // A parity check is due next cycle.
    logic                   par_prev;  // Parity of the previous data bits.
    logic [1:0]             err_cnt;   // Remaining cycles of error hold.
  } state_t;

endpackage : regbuf_pkg

//--- regbuf.sv
module regbuf (
  input  wire logic                                 clk_i,
  input  wire logic                                 rst_n_i,
  input  wire logic                                 ce_i,
  input  wire logic                                 in_valid_i,
  output logic                                      in_ready_o,
  input  wire logic [regbuf_pkg::MAIN_W-1:0]        main_data_inputs_i,
  input  wire logic                                 chip_select_zero_n_i,
  input  wire logic                                 chip_select_one_n_i,
  input  wire logic [regbuf_pkg::PAIR_W-1:0]        termination_inputs_i,
  input  wire logic [regbuf_pkg::PAIR_W-1:0]        clock_enable_inputs_i,
  input  wire logic                                 select_gating_enable_i,
  input  wire logic                                 parity_bit_in_i,
  output logic                                      out_valid_o,
  input  wire logic                                 out_ready_i,
  output logic [regbuf_pkg::MAIN_W-1:0]             main_data_outputs_a_o,
  output logic [regbuf_pkg::MAIN_W-1:0]             main_data_outputs_b_o,
  output logic [regbuf_pkg::PAIR_W-1:0]             registered_select_outputs_a_o,
  output logic [regbuf_pkg::PAIR_W-1:0]             registered_select_outputs_b_o,
  output logic [regbuf_pkg::PAIR_W-1:0]             termination_outputs_a_o,
  output logic [regbuf_pkg::PAIR_W-1:0]             termination_outputs_b_o,
  output logic [regbuf_pkg::PAIR_W-1:0]             clock_enable_outputs_a_o,
  output logic [regbuf_pkg::PAIR_W-1:0]             clock_enable_outputs_b_o,
  output logic                                      parity_error_flag_n_o,
  output logic                                      parity_error_flag_n_oe_o
);

  logic                    rst_meta;    // First synchroniser stage.
  logic                    rst_sync;    // Released reset used by all state.
  regbuf_pkg::state_t      st;          // Registered state.
  regbuf_pkg::state_t      next_st;     // Next state.
  regbuf_pkg::entry_t      head;        // Oldest buffered entry.
  logic                    push;        // Input word accepted this cycle.
  logic                    pop;         // Buffered word moved to the outputs.
  logic                    par_bad;     // Odd count of ones seen this cycle.

  // Reset asserts at once through the async clear and releases two edges
  // later, so the release never lands near a clock edge inside the state.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // The buffer only accepts words once reset is released and it has room.
  assign in_ready_o = rst_sync && (st.cnt < 2'(regbuf_pkg::BUF_DEPTH));
  assign head       = st.mem[st.rd];
  assign push       = ce_i && in_valid_i && in_ready_o;
  assign pop        = ce_i && (st.cnt != 2'h0) && out_ready_i;
  // Data parity and the late parity bit together must hold an even count.
  assign par_bad    = st.par_pend && (st.par_prev ^ parity_bit_in_i);

  // Next-state logic; a low clock enable leaves everything as it stands.
  always_comb
  begin
    next_st = st;
    if (ce_i)
    begin
      next_st.out_valid = 1'b0;
      // Drain one word into the output registers.
      if (pop)
      begin
        next_st.q.sel_n = head.w.sel_n;
        next_st.q.odt   = head.w.odt;
        next_st.q.cke   = head.w.cke;
        // A gated word leaves the main data as it was.
        if (!head.gate)
        begin
          next_st.q.main = head.w.main;
        end
        next_st.rd        = ~st.rd;
        next_st.out_valid = 1'b1;
      end
      // Capture a new word; gating is judged with the word's own selects.
      if (push)
      begin
        next_st.mem[st.wr].gate   = select_gating_enable_i &&
                                    chip_select_zero_n_i &&
                                    chip_select_one_n_i;
        next_st.mem[st.wr].w.main  = main_data_inputs_i;
        next_st.mem[st.wr].w.sel_n = {chip_select_one_n_i, chip_select_zero_n_i};
        next_st.mem[st.wr].w.odt   = termination_inputs_i;
        next_st.mem[st.wr].w.cke   = clock_enable_inputs_i;
        next_st.wr = ~st.wr;
      end
      // Occupancy moves only when exactly one side acts.
      if (push && !pop)
      begin
        next_st.cnt = st.cnt + 2'h1;
      end
      else if (pop && !push)
      begin
        next_st.cnt = st.cnt - 2'h1;
      end
      // A word with both selects high is not checked, so it cannot set the flag.
      next_st.par_pend = push && !(chip_select_zero_n_i && chip_select_one_n_i);
      next_st.par_prev = ^main_data_inputs_i;
      // A fresh error reloads the hold and wins over the count-down.
      if (par_bad)
      begin
        next_st.err_cnt = regbuf_pkg::ERR_HOLD_CYC;
      end
      else if (st.err_cnt != 2'h0)
      begin
        next_st.err_cnt = st.err_cnt - 2'h1;
      end
    end
  end

  // State register; the async clear empties every register at once.
  always_ff @(posedge clk_i or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Both copies come from the same flip-flops, so they can never differ.
  assign main_data_outputs_a_o         = st.q.main;
  assign main_data_outputs_b_o         = st.q.main;
  assign registered_select_outputs_a_o = st.q.sel_n;
  assign registered_select_outputs_b_o = st.q.sel_n;
  assign termination_outputs_a_o       = st.q.odt;
  assign termination_outputs_b_o       = st.q.odt;
  assign clock_enable_outputs_a_o      = st.q.cke;
  assign clock_enable_outputs_b_o      = st.q.cke;
  assign out_valid_o                   = st.out_valid;
  // Open-drain flag: the pin is pulled low only while an error is held.
  assign parity_error_flag_n_oe_o      = (st.err_cnt != 2'h0);
  assign parity_error_flag_n_o         = (st.err_cnt == 2'h0);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_sync);

  // Outputs sit low and the flag released whenever reset is held.
  AST_RESET_LOW: assert property (@(posedge clk_i) disable iff (1'b0)
    !rst_sync |-> (main_data_outputs_a_o == regbuf_pkg::MAIN_RST) &&
    (termination_outputs_a_o == regbuf_pkg::PAIR_RST) && parity_error_flag_n_o)
    else $error("Outputs not low during reset.");
  // No word is taken, shown or flagged while the synchronised reset is low.
  AST_IGNORE_IN_RESET: assert property (@(posedge clk_i) disable iff (1'b0)
    !rst_sync |-> !in_ready_o && !out_valid_o && !parity_error_flag_n_oe_o)
    else $error("Block active during reset.");
  // On release nothing has reached the outputs yet.
  AST_CLEAN_RELEASE: assert property (@(posedge clk_i) disable iff (1'b0)
    $rose(rst_sync) |-> (main_data_outputs_b_o == regbuf_pkg::MAIN_RST) &&
    (clock_enable_outputs_b_o == regbuf_pkg::PAIR_RST) && !out_valid_o)
    else $error("Outputs moved while leaving reset.");
  // A low clock enable is no crossing, so nothing may move.
  AST_FREEZE: assert property (!ce_i |=> $stable(st))
    else $error("State changed with clock enable low.");
  // A gated word must leave the main data exactly as it was.
  AST_GATED_HOLD: assert property (pop && head.gate |=> $stable(main_data_outputs_a_o))
    else $error("Gated word changed the main data.");
  // An ungated word reaches the main data one edge after it leaves the buffer.
  AST_UNGATED_LOAD: assert property (pop && !head.gate |=>
    main_data_outputs_a_o == $past(head.w.main))
    else $error("Main data did not load.");
  // Selects, termination and clock enable load with every word, gated or not.
  AST_SIDE_LOAD: assert property (pop |=>
    (registered_select_outputs_b_o == $past(head.w.sel_n)) &&
    (termination_outputs_b_o == $past(head.w.odt)) &&
    (clock_enable_outputs_a_o == $past(head.w.cke)))
    else $error("Select, termination or clock enable did not load.");
  // With gating disabled a stored word is never marked as gated.
  AST_NO_GATE_WHEN_OFF: assert property (push && !select_gating_enable_i |=>
    !st.mem[~st.wr].gate)
    else $error("Word gated with gating disabled.");
  // A mismatching parity bit pulls the flag low for two cycles.
  AST_ERR_HOLD: assert property (ce_i && st.par_pend && (st.par_prev != parity_bit_in_i) |=>
    !parity_error_flag_n_o ##1 !parity_error_flag_n_o)
    else $error("Parity error not held two cycles.");
  // A matching parity bit leaves an idle flag released.
  AST_PAR_GOOD: assert property (ce_i && st.par_pend && (st.par_prev == parity_bit_in_i) &&
    (st.err_cnt == 2'h0) |=> parity_error_flag_n_o)
    else $error("Error flagged on good parity.");
  // A full buffer must refuse, or a captured word would be lost.
  AST_NO_OVERFLOW: assert property ((st.cnt == 2'(regbuf_pkg::BUF_DEPTH)) |-> !in_ready_o)
    else $error("Buffer accepts while full.");
  // The A and B copies of every output come from one register.
  AST_COPIES_EQUAL: assert property (
    (main_data_outputs_a_o == main_data_outputs_b_o) &&
    (registered_select_outputs_a_o == registered_select_outputs_b_o) &&
    (termination_outputs_a_o == termination_outputs_b_o) &&
    (clock_enable_outputs_a_o == clock_enable_outputs_b_o))
    else $error("Output copies differ.");

  // Main scenarios: a gated word, an error, a full buffer and a drain after a stall.
  COV_GATED: cover property (pop && head.gate);
  COV_ERROR: cover property (ce_i && par_bad);
  COV_FULL: cover property (st.cnt == 2'(regbuf_pkg::BUF_DEPTH) && in_valid_i);
  COV_STALL_DRAIN: cover property (!out_ready_i ##1 pop);

endmodule : regbuf

//--- ready_sink.sv
// Receiver model on the far side of the output buffer: it only grants or withholds ready.
module ready_sink (
  input  wire logic       clk_i,
  input  wire logic [1:0] mode_i,
  output logic            out_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Mode 0 always takes, 1 stalls at random, 2 stalls until released.
  // Ready moves at the falling edge so it never races the capturing edge.
  initial
  begin
    out_ready_o = 1'b1;
    forever
    begin
      @(negedge clk_i);
      out_ready_o <= (mode_i == 2'h0) || ((mode_i == 2'h1) && (($urandom % 3) != 0));
    end
  end
endmodule : ready_sink

//--- tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_n_i, ce_i, in_valid_i, in_ready_o, gate_en, par_in, out_valid_o;
  logic out_ready_i, flag_n, flag_oe, taken, rnd_ce, inject, next_par;
  logic [1:0] sink_mode;
  logic [21:0] qa, qb, last_main;
  logic [1:0] sa, sb, ta, tb_b, ka, kb;
  regbuf_pkg::word_t din, e;
  regbuf_pkg::word_t exp_q[$];    // Words noted by the driver, oldest first.
  int n_errors, comparisons;
  // The fixed-level pins have no ports; the board ties them outside this block.
  regbuf dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .in_valid_i(in_valid_i),
    .in_ready_o(in_ready_o), .main_data_inputs_i(din.main), .chip_select_zero_n_i(din.sel_n[0]),
    .chip_select_one_n_i(din.sel_n[1]), .termination_inputs_i(din.odt),
    .clock_enable_inputs_i(din.cke), .select_gating_enable_i(gate_en), .parity_bit_in_i(par_in),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .main_data_outputs_a_o(qa),
    .main_data_outputs_b_o(qb), .registered_select_outputs_a_o(sa),
    .registered_select_outputs_b_o(sb), .termination_outputs_a_o(ta),
    .termination_outputs_b_o(tb_b), .clock_enable_outputs_a_o(ka), .clock_enable_outputs_b_o(kb),
    .parity_error_flag_n_o(flag_n), .parity_error_flag_n_oe_o(flag_oe));
  ready_sink sink (.clk_i(clk_i), .mode_i(sink_mode), .out_ready_o(out_ready_i));
  // Free-running 125 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Counts every comparison and reports a difference at once.
  task automatic check(input string name, input logic [27:0] seen, input logic [27:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic final_report;
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  // Presents one word from a falling edge until it is taken or 64 rising edges pass; ends at a falling edge.
  task automatic send(input regbuf_pkg::word_t w, input logic gate);
    regbuf_pkg::word_t x;
    int n;
    n = 0;
    din = w;
    gate_en = gate;
    in_valid_i = 1'b1;
    do
    begin
      @(posedge clk_i);
      taken = ce_i && in_ready_o;
      n++;
      if (taken)
      begin
        x = w;
        if (gate && (w.sel_n == 2'h3)) x.main = last_main;
        last_main = x.main;
        exp_q.push_back(x);
        next_par = ^w.main;
      end
      @(negedge clk_i);
      if (taken) par_in = next_par ^ inject;
      ce_i = rnd_ce ? (($urandom % 4) != 0) : 1'b1;
    end while (!taken && n < 64);
    check("word accepted", 28'(taken), 28'h1);
  endtask : send
  function automatic regbuf_pkg::word_t rand_word(input logic [1:0] sel);
    rand_word = 28'($urandom);
    rand_word.sel_n = sel;
  endfunction : rand_word
  // Reset asserted between edges, with junk inputs, then released with quiet inputs.
  task automatic do_reset;
    rst_n_i = 1'b0;
    din = rand_word(2'h0);
    in_valid_i = 1'b1;
    #1 check("outputs in reset", {qa, sa, ta, ka}, 28'h0);
    check("flag in reset", 28'({flag_n, flag_oe, out_valid_o, in_ready_o}), 28'h8);
    repeat (12) @(negedge clk_i);
    din = '0;
    in_valid_i = 1'b0;
    exp_q.delete();
    last_main = '0;
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    check("outputs after release", {qa | qb, sb, tb_b, kb}, 28'h0);
    check("idle after release", 28'({out_valid_o, flag_n}), 28'h1);
  endtask : do_reset
  // Result side: each output pulse retires the oldest noted word.
  always @(posedge clk_i)
    if (rst_n_i && ce_i && out_valid_o)
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 28'hFFFFFFF;
      check("copy a", {qa, sa, ta, ka}, e);
      check("copy b", {qb, sb, tb_b, kb}, e);
    end
  // One parity case: a checked word, then the flag over the following cycles.
  task automatic par_case(input logic bad);
    inject = bad;
    send(rand_word(2'h2), 1'b1);
    in_valid_i = 1'b0;
    inject = 1'b0;
    repeat (2)
    begin
      @(negedge clk_i);
      check("flag held", 28'({flag_n, flag_oe}), 28'({~bad, bad}));
    end
    @(negedge clk_i);
    check("flag released", 28'({flag_n, flag_oe}), 28'h2);
  endtask : par_case
  initial
  begin
    {ce_i, gate_en, par_in, rnd_ce, inject, next_par} = 6'h20;
    {sink_mode, n_errors, comparisons} = '0;
    void'($urandom(32'h7add));
    do_reset;
    for (int i = 0; i < 8; i++) send(rand_word(i[1:0]), i[2]);
    sink_mode = 2'h1;
    rnd_ce = 1'b1;
    repeat (300) send(rand_word(2'($urandom)), 1'($urandom));
    // Drain whatever the random phase left before filling the buffer on purpose.
    rnd_ce = 1'b0;
    in_valid_i = 1'b0;
    sink_mode = 2'h0;
    @(negedge clk_i) ce_i = 1'b1;
    repeat (4) @(negedge clk_i);
    sink_mode = 2'h2;
    repeat (2) send(rand_word(2'h1), 1'b1);
    in_valid_i = 1'b0;
    check("ready when full", 28'(in_ready_o), 28'h0);
    sink_mode = 2'h0;
    repeat (12) @(negedge clk_i);
    par_case(1'b0);
    par_case(1'b1);
    par_case(1'b1);
    check("words left", 28'(exp_q.size()), 28'h0);
    do_reset;
    final_report;
  end
  // Cut a hang short well after the sequence should have ended.
  initial
  begin
    #100000;
    n_errors++;
    final_report;
  end
endmodule : tb
